// ==== rtl/bqf_filter_bank.v ====
// Purpose: twelve shared biquad sections for four record channels
// Assumes: samples arrive at most once per 14 clocks, register access is byte wide
// Notes:   one section is evaluated per clock, so a frame takes 12 clocks
`timescale 1ns/100ps
`include "bqf_regs.vh"

module bqf_filter_bank (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // register access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_page_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // bank control
  input wire two_ch_mode_i,
  input wire bank_switch_i,
  output reg active_bank_o,
  // sample input
  input wire smp_valid_i,
  input wire [31:0] smp_ch1_i,
  input wire [31:0] smp_ch2_i,
  input wire [31:0] smp_ch3_i,
  input wire [31:0] smp_ch4_i,
  // sample output
  output reg smp_valid_o,
  output reg [31:0] smp_ch1_o,
  output reg [31:0] smp_ch2_o,
  output reg [31:0] smp_ch3_o,
  output reg [31:0] smp_ch4_o,
  output reg busy_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte index of a coefficient register, or 8'hff when unmapped
  function [7:0] coef_index;
    input [7:0] page;
    input [6:0] addr;
    begin
      if (addr < `BQF_COEF_FIRST_REG) begin
        coef_index = 8'hff;
      end else if (page == `BQF_PAGE_COEF_LO) begin
        coef_index = {1'b0, addr - `BQF_COEF_FIRST_REG};
      end else if (page == `BQF_PAGE_COEF_HI) begin
        coef_index = {1'b0, addr - `BQF_COEF_FIRST_REG} + `BQF_BYTES_PER_PAGE;
      end else begin
        coef_index = 8'hff;
      end
    end
  endfunction

  // sections used per channel for an allocation code
  function [1:0] stages_for;
    input [1:0] alloc;
    begin
      case (alloc)
        `BQF_ALLOC_BYPASS: stages_for = 2'd0;
        `BQF_ALLOC_ONE: stages_for = 2'd1;
        `BQF_ALLOC_TWO: stages_for = 2'd2;
        default: stages_for = 2'd3;
      endcase
    end
  endfunction

  // page 0 register holding the allocation field
  function is_alloc_reg;
    input [7:0] page;
    input [6:0] addr;
    begin
      is_alloc_reg = (page == `BQF_PAGE_CFG) && (addr == `BQF_REG_ALLOC);
    end
  endfunction

  // value leaving a channel at the last step: fresh result if that step filters it
  function [31:0] chan_result;
    input [1:0] ch;
    input [1:0] cur_ch;
    input cur_active;
    input [31:0] fresh;
    input [31:0] held;
    begin
      if (cur_active && cur_ch == ch) begin
        chan_result = fresh;
      end else begin
        chan_result = held;
      end
    end
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // one flop byte per register keeps host reads trivial, at the cost of area
  reg [7:0] coef_q [0:`BQF_NUM_BYTES-1];
  reg [31:0] x1_q [0:`BQF_NUM_SECT-1];
  reg [31:0] x2_q [0:`BQF_NUM_SECT-1];
  reg [31:0] y1_q [0:`BQF_NUM_SECT-1];
  reg [31:0] y2_q [0:`BQF_NUM_SECT-1];
  reg [31:0] work_q [0:`BQF_NUM_CH-1];
  reg [1:0] alloc_q;
  reg [1:0] run_stages_q;
  reg run_two_ch_q;
  reg [1:0] state_q;
  reg [3:0] step_q;
  integer i;
  integer j;

  // ----------------------------------------
  // current step decode
  // ----------------------------------------
  wire [1:0] step_ch;
  wire [1:0] step_stage;
  wire step_active;
  wire [3:0] phys_sect;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire alloc_sel;
  reg [7:0] base;
  reg [31:0] c_n0;
  reg [31:0] c_n1;
  reg [31:0] c_n2;
  reg [31:0] c_d1;
  reg [31:0] c_d2;
  wire [31:0] y0;

  // step k serves channel k mod 4 as stage k div 4, so ascending order cascades
  assign step_ch = step_q[1:0];
  assign step_stage = step_q[3:2];
  assign step_active = (step_stage < run_stages_q) && !(run_two_ch_q && step_ch[1]);
  // two-channel bank 1 borrows the coefficients of channels 3 and 4
  assign phys_sect = (run_two_ch_q && active_bank_o) ? step_q + 4'd2 : step_q;
  assign wr_idx = coef_index(reg_page_i, reg_addr_i);
  assign rd_idx = coef_index(reg_page_i, reg_addr_i);
  assign alloc_sel = is_alloc_reg(reg_page_i, reg_addr_i);

  always @* begin
    base = {4'h0, phys_sect} * `BQF_SECT_BYTES;
    c_n0 = {coef_q[base], coef_q[base+8'd1], coef_q[base+8'd2], coef_q[base+8'd3]};
    c_n1 = {coef_q[base+8'd4], coef_q[base+8'd5], coef_q[base+8'd6], coef_q[base+8'd7]};
    c_n2 = {coef_q[base+8'd8], coef_q[base+8'd9], coef_q[base+8'd10], coef_q[base+8'd11]};
    c_d1 = {coef_q[base+8'd12], coef_q[base+8'd13], coef_q[base+8'd14], coef_q[base+8'd15]};
    c_d2 = {coef_q[base+8'd16], coef_q[base+8'd17], coef_q[base+8'd18], coef_q[base+8'd19]};
  end

  bqf_section_mac u_mac (
    .x0_i(work_q[step_ch]),
    .x1_i(x1_q[step_q]),
    .x2_i(x2_q[step_q]),
    .y1_i(y1_q[step_q]),
    .y2_i(y2_q[step_q]),
    .numerator_coef_zero_i(c_n0),
    .numerator_coef_one_i(c_n1),
    .numerator_coef_two_i(c_n2),
    .denominator_coef_one_i(c_d1),
    .denominator_coef_two_i(c_d2),
    .y0_o(y0)
  );

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  // steps that filter nothing leave the running value untouched
  wire step_last;
  wire [31:0] out_ch1;
  wire [31:0] out_ch2;
  wire [31:0] out_ch3;
  wire [31:0] out_ch4;

  assign step_last = (step_q == `BQF_LAST_STEP);
  assign out_ch1 = chan_result(2'd0, step_ch, step_active, y0, work_q[0]);
  assign out_ch2 = chan_result(2'd1, step_ch, step_active, y0, work_q[1]);
  assign out_ch3 = chan_result(2'd2, step_ch, step_active, y0, work_q[2]);
  assign out_ch4 = chan_result(2'd3, step_ch, step_active, y0, work_q[3]);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // coefficient writes are taken at any time; outside the bank-switch scheme the
  // host is expected to finish loading before recording starts
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alloc_q <= `BQF_ALLOC_RST;
      reg_rdata_o <= 8'h00;
      for (i = 0; i < `BQF_NUM_BYTES; i = i + 1) begin
        // n0 = 0x7fffffff, rest zero: flat unity response
        if (i % 20 == 0) begin
          coef_q[i] <= `BQF_N0_RST_MSB;
        end else if (i % 20 < 4) begin
          coef_q[i] <= `BQF_N0_RST_LOW;
        end else begin
          coef_q[i] <= 8'h00;
        end
      end
    end else begin
      if (reg_wr_i) begin
        if (alloc_sel) begin
          alloc_q <= reg_wdata_i[`BQF_ALLOC_LSB+1:`BQF_ALLOC_LSB];
        end
        if (wr_idx != 8'hff) begin
          coef_q[wr_idx] <= reg_wdata_i;
        end
      end
      if (reg_rd_i) begin
        if (alloc_sel) begin
          reg_rdata_o <= {4'h0, alloc_q, 2'h0};
        end else if (rd_idx != 8'hff) begin
          reg_rdata_o <= coef_q[rd_idx];
        end else begin
          reg_rdata_o <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // sequencer and datapath
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
      run_stages_q <= 2'd0;
      run_two_ch_q <= 1'b0;
      active_bank_o <= 1'b0;
      busy_o <= 1'b0;
      smp_valid_o <= 1'b0;
      smp_ch1_o <= 32'h00000000;
      smp_ch2_o <= 32'h00000000;
      smp_ch3_o <= 32'h00000000;
      smp_ch4_o <= 32'h00000000;
      for (j = 0; j < `BQF_NUM_CH; j = j + 1) begin
        work_q[j] <= 32'h00000000;
      end
      for (j = 0; j < `BQF_NUM_SECT; j = j + 1) begin
        x1_q[j] <= 32'h00000000;
        x2_q[j] <= 32'h00000000;
        y1_q[j] <= 32'h00000000;
        y2_q[j] <= 32'h00000000;
      end
    end else begin
      smp_valid_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // a sample arriving while busy is dropped; the rate leaves ample slack
          if (smp_valid_i) begin
            work_q[0] <= smp_ch1_i;
            work_q[1] <= smp_ch2_i;
            work_q[2] <= smp_ch3_i;
            work_q[3] <= smp_ch4_i;
            run_stages_q <= stages_for(alloc_q);
            run_two_ch_q <= two_ch_mode_i;
            active_bank_o <= bank_switch_i;
            step_q <= 4'h0;
            busy_o <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          // history follows the logical slot, so a bank switch keeps filter state
          if (step_active) begin
            work_q[step_ch] <= y0;
            x1_q[step_q] <= work_q[step_ch];
            x2_q[step_q] <= x1_q[step_q];
            y1_q[step_q] <= y0;
            y2_q[step_q] <= y1_q[step_q];
          end
          if (step_last) begin
            smp_valid_o <= 1'b1;
            smp_ch1_o <= out_ch1;
            smp_ch2_o <= out_ch2;
            smp_ch3_o <= out_ch3;
            smp_ch4_o <= out_ch4;
            busy_o <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== rtl/bqf_regs.vh ====
// Purpose: constants for the record-path biquad filter bank
// Assumes: one 8-bit register map, pages of 128 registers, bank 0 only
// Notes:   coefficients are stored as signed 32-bit words, most significant byte first
`ifndef BQF_REGS_VH
`define BQF_REGS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define BQF_PAGE_CFG 8'h00
`define BQF_REG_ALLOC 7'h72
`define BQF_ALLOC_LSB 2
`define BQF_ALLOC_RST 2'h2
`define BQF_PAGE_COEF_LO 8'h08
`define BQF_PAGE_COEF_HI 8'h09
`define BQF_COEF_FIRST_REG 7'h08
`define BQF_BYTES_PER_PAGE 8'h78

// ----------------------------------------
// section layout
// ----------------------------------------
`define BQF_NUM_SECT 12
`define BQF_NUM_CH 4
`define BQF_NUM_BYTES 240
`define BQF_SECT_BYTES 8'h14
`define BQF_OFS_N0 8'h00
`define BQF_OFS_N1 8'h04
`define BQF_OFS_N2 8'h08
`define BQF_OFS_D1 8'h0c
`define BQF_OFS_D2 8'h10
`define BQF_N0_RST_MSB 8'h7f
`define BQF_N0_RST_LOW 8'hff

// ----------------------------------------
// allocation codes
// ----------------------------------------
`define BQF_ALLOC_BYPASS 2'h0
`define BQF_ALLOC_ONE 2'h1
`define BQF_ALLOC_TWO 2'h2
`define BQF_ALLOC_THREE 2'h3
`define BQF_LAST_STEP 4'hb

`endif

// ==== rtl/bqf_section_mac.v ====
// Purpose: one second-order recursive section, evaluated in a single cycle
// Assumes: coefficients and states are signed 32-bit, unity is 2^31
// Notes:   result is rounded to nearest and saturates instead of wrapping
`timescale 1ns/100ps

module bqf_section_mac (
  // input sample and stored history
  input wire [31:0] x0_i,
  input wire [31:0] x1_i,
  input wire [31:0] x2_i,
  input wire [31:0] y1_i,
  input wire [31:0] y2_i,
  // coefficients
  input wire [31:0] numerator_coef_zero_i,
  input wire [31:0] numerator_coef_one_i,
  input wire [31:0] numerator_coef_two_i,
  input wire [31:0] denominator_coef_one_i,
  input wire [31:0] denominator_coef_two_i,
  // result
  output reg [31:0] y0_o
);

  function signed [66:0] sx;
    input [31:0] v;
    begin
      sx = {{35{v[31]}}, v};
    end
  endfunction

  wire signed [66:0] p_n0;
  wire signed [66:0] p_n1;
  wire signed [66:0] p_n2;
  wire signed [66:0] p_d1;
  wire signed [66:0] p_d2;
  wire signed [66:0] acc;
  wire [35:0] acc_hi;

  // y*2^31 = n0*x + 2*n1*x1 + n2*x2 + 2*d1*y1 + d2*y2
  assign p_n0 = sx(numerator_coef_zero_i) * sx(x0_i);
  assign p_n1 = sx(numerator_coef_one_i) * sx(x1_i);
  assign p_n2 = sx(numerator_coef_two_i) * sx(x2_i);
  assign p_d1 = sx(denominator_coef_one_i) * sx(y1_i);
  assign p_d2 = sx(denominator_coef_two_i) * sx(y2_i);
  // half an lsb of rounding lets the reset n0 pass samples below half scale unchanged
  assign acc = p_n0 + (p_n1 <<< 1) + p_n2 + (p_d1 <<< 1) + p_d2 + 67'sh40000000;
  assign acc_hi = acc[66:31];

  // clip to 32 bits; a wrap would turn an overload into a full-scale click
  always @* begin
    if (acc_hi[35:31] == 5'h00 || acc_hi[35:31] == 5'h1f) begin
      y0_o = acc_hi[31:0];
    end else if (acc_hi[35]) begin
      y0_o = 32'h80000000;
    end else begin
      y0_o = 32'h7fffffff;
    end
  end

endmodule

// ==== verification/bqf_filter_bank_asserts.sv ====
// Purpose: port-level checks on the biquad filter bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only ports of the bank, bound from the testbench
`timescale 1ns/100ps

module bqf_filter_bank_asserts (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // register access
  input wire reg_rd_i,
  input wire [7:0] reg_page_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  // stream
  input wire active_bank_o,
  input wire smp_valid_i,
  input wire smp_valid_o,
  input wire [31:0] smp_ch1_o,
  input wire busy_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // a frame is only taken while idle
  wire take = smp_valid_i && !busy_o;

  // ----------------------------------------
  // stream timing
  // ----------------------------------------
  a_frame_latency: assert property (take |-> ##13 smp_valid_o)
    else $error("frame answer not after 13 cycles");
  a_take_busy: assert property (take |=> busy_o)
    else $error("busy not raised on frame");
  a_busy_span: assert property ($rose(busy_o) |-> busy_o[*8] ##1 busy_o[*4] ##1 !busy_o)
    else $error("busy span not 12 cycles");
  a_valid_pulse: assert property (smp_valid_o |=> !smp_valid_o)
    else $error("output strobe longer than one cycle");
  a_valid_end: assert property (smp_valid_o |-> $fell(busy_o))
    else $error("output strobe outside frame end");
  a_data_hold: assert property (!smp_valid_o |-> $stable(smp_ch1_o))
    else $error("output data moved between frames");
  a_bank_frame: assert property ($changed(active_bank_o) |-> $past(take))
    else $error("bank changed off a sample boundary");

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_rd: assert property (reg_rd_i && reg_page_i == 8'h08 && reg_addr_i < 7'h08
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped coefficient register not zero");
  a_alloc_bits: assert property (reg_rd_i && reg_page_i == 8'h00 && reg_addr_i == 7'h72
    |=> (reg_rdata_o & 8'hf3) == 8'h00)
    else $error("allocation register spare bits not zero");

  c_take: cover property (take);
  c_refused: cover property (busy_o && smp_valid_i);
  c_bank: cover property ($changed(active_bank_o));
endmodule

// ==== verification/tb.sv ====
// Purpose: directed testbench for the biquad filter bank
// Assumes: 250 MHz clock, reset held 10 cycles
// Notes:   only n0 is programmed, so section history never matters
`timescale 1ns/100ps

module tb;
  reg ref_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [7:0] reg_page_i = 8'h00;
  reg [6:0] reg_addr_i = 7'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg two_ch_mode_i = 1'b0;
  reg bank_switch_i = 1'b0;
  reg smp_valid_i = 1'b0;
  reg [31:0] smp_ch1_i = 32'h0800_0000;
  reg [31:0] smp_ch2_i = 32'h1000_0000;
  reg [31:0] smp_ch3_i = 32'h1800_0000;
  reg [31:0] smp_ch4_i = 32'h2000_0000;
  wire [7:0] reg_rdata_o;
  wire active_bank_o, smp_valid_o, busy_o;
  wire [31:0] smp_ch1_o, smp_ch2_o, smp_ch3_o, smp_ch4_o;
  integer n_mismatch = 0;
  integer n_compared = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  bqf_filter_bank u_bqf_filter_bank (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_page_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .two_ch_mode_i, .bank_switch_i, .active_bank_o,
    .smp_valid_i, .smp_ch1_i, .smp_ch2_i, .smp_ch3_i, .smp_ch4_i, .smp_valid_o, .smp_ch1_o,
    .smp_ch2_o, .smp_ch3_o, .smp_ch4_o, .busy_o);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task acc(input w, input [7:0] p, input [6:0] a, input [7:0] d);
    begin
      @(posedge ref_clk_i);
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_page_i <= p;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      // one spare edge so read data has landed
      @(posedge ref_clk_i);
      #1;
      if (!w) chk("rdata", d, reg_rdata_o);
    end
  endtask

  // section s, byte offset o: twenty bytes a section, pages split at byte 120
  task coef(input w, input integer s, input integer o, input [31:0] v);
    integer i, b;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        b = 20 * s + o + i;
        acc(w, b < 120 ? 8'h08 : 8'h09, 7'(8 + b % 120), v[31 - 8 * i -: 8]);
      end
    end
  endtask

  task frame(input [31:0] e1, input [31:0] e2, input [31:0] e3, input [31:0] e4);
    integer i;
    begin
      @(posedge ref_clk_i);
      smp_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      smp_valid_i <= 1'b0;
      @(posedge ref_clk_i);
      // strobe while busy must be ignored
      smp_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      smp_valid_i <= 1'b0;
      i = 0;
      while (smp_valid_o !== 1'b1 && i < 20) begin
        @(posedge ref_clk_i);
        #1;
        i = i + 1;
      end
      chk("valid", 1, smp_valid_o);
      chk("ch1", e1, smp_ch1_o);
      chk("ch2", e2, smp_ch2_o);
      chk("ch3", e3, smp_ch3_o);
      chk("ch4", e4, smp_ch4_o);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      acc(0, 8'h00, 7'h72, 8'h08);
      coef(0, 11, 0, 32'h7fff_ffff);
      acc(0, 8'h09, 7'h7f, 8'h00);
      acc(0, 8'h08, 7'h07, 8'h00);
      frame(smp_ch1_i, smp_ch2_i, smp_ch3_i, smp_ch4_i);
      $display("test t_reset done");
    end
  endtask

  task t_alloc;
    integer k;
    begin
      coef(1, 0, 0, 32'h4000_0000);
      coef(1, 2, 0, 32'h2000_0000);
      coef(1, 4, 0, 32'h4000_0000);
      coef(1, 8, 0, 32'h4000_0000);
      coef(0, 8, 0, 32'h4000_0000);
      for (k = 0; k < 4; k = k + 1) begin
        acc(1, 8'h00, 7'h72, 8'(k << 2));
        acc(0, 8'h00, 7'h72, 8'(k << 2));
        frame(smp_ch1_i >> k, smp_ch2_i, k == 0 ? smp_ch3_i : smp_ch3_i >> 2,
          smp_ch4_i);
      end
      $display("test t_alloc done");
    end
  endtask

  task t_bank;
    begin
      acc(1, 8'h00, 7'h72, 8'h04);
      @(posedge ref_clk_i);
      two_ch_mode_i <= 1'b1;
      frame(smp_ch1_i >> 1, smp_ch2_i, smp_ch3_i, smp_ch4_i);
      chk("bank", 0, active_bank_o);
      @(posedge ref_clk_i);
      bank_switch_i <= 1'b1;
      frame(smp_ch1_i >> 2, smp_ch2_i, smp_ch3_i, smp_ch4_i);
      chk("bank", 1, active_bank_o);
      $display("test t_bank done");
    end
  endtask

  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_alloc;
    t_bank;
    complete_run;
  end

  // whole run needs a few hundred cycles
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
endmodule

bind bqf_filter_bank bqf_filter_bank_asserts u_bqf_filter_bank_asserts (.ref_clk_i, .rst_n_i,
  .reg_rd_i, .reg_page_i, .reg_addr_i, .reg_rdata_o, .active_bank_o, .smp_valid_i,
  .smp_valid_o, .smp_ch1_o, .busy_o);
